// ==== pkg/rsc_pkg.sv ====
// Overview of operation
// RULE_01: Reset input low for at least 1 us gives a full reset.
// RULE_02: Reset returns every register to default and recaptures all straps.
// RULE_03: Shared pin defaults to active-low power-down input.
// RULE_04: In interrupt mode the shared pin pulls low while interrupt pending.
// RULE_05: Software must enable interrupt mode; otherwise pin stays power-down.
// RULE_06: Straps sampled at reset select modes; pins then resume normal use.
// RULE_07: Four address straps captured as address bits 4:1 into port control.
// RULE_08: Address bit 0 selects port: first port even, second port odd.
// RULE_09: Unfitted address strap reads as zero due to weak pull-down.
// RULE_10: Negotiation strap high negotiates, low forces the strapped mode.
// RULE_11: Forced mode straps: 00 10H, 01 10F, 10 100H, 11 100F.
// RULE_12: Advertised: 00 10H/F, 01 100H/F, 10 both half, 11 all; default 111.
// RULE_13: Captured straps load basic control and advertisement fields.
// RULE_14: Reduced strap 0 gives MII; 1 with serial 0 gives RMII.
// RULE_15: Board must strap both ports alike for the reduced interface.
// RULE_16: Reference is 25 MHz in MII mode, 50 MHz in RMII mode.
// RULE_17: Strap values freeze at reset release; later pin activity ignored.
package rsc_pkg;

  localparam int NUM_PORTS = 2;
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam int IRQ_W = 2 * NUM_PORTS;

  // -------------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------------
  localparam logic [REG_AW-1:0] ADDR_CTRL0 = 4'h0;
  localparam logic [REG_AW-1:0] ADDR_CTRL1 = 4'h1;
  localparam logic [REG_AW-1:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [REG_AW-1:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [REG_AW-1:0] ADDR_GSTAT = 4'h4;

  // Event bits inside a port's pair of status bits
  localparam int EV_PD_ENTER = 0;
  localparam int EV_PD_EXIT = 1;

  // Ability bits of the advertisement field
  localparam logic [3:0] ADV_10H = 4'h1;
  localparam logic [3:0] ADV_10F = 4'h2;
  localparam logic [3:0] ADV_100H = 4'h4;
  localparam logic [3:0] ADV_100F = 4'h8;

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MII_REF_MHZ = 25;
  localparam int RMII_REF_MHZ = 50;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MAC_MII,
    MAC_RMII,
    MAC_SNI
  } rsc_mac_mode_t;

  typedef enum logic [1:0] {
    ST_CAPTURE,
    ST_INIT,
    ST_RUN
  } rsc_state_t;

  typedef struct packed {
    logic neg_en;
    logic mode_hi;
    logic mode_lo;
    logic reduced;
    logic serial;
  } rsc_strap_t;

  typedef struct packed {
    logic pd_state;
    rsc_mac_mode_t mac_mode;
    logic [3:0] adv;
    logic duplex_full;
    logic speed_100;
    logic neg_en;
    logic irq_pin_en;
    logic [4:0] station_addr;
  } rsc_ctrl_t;

  typedef struct packed {
    logic [REG_DW-4:0] zero;
    logic rmii_mismatch;
    logic ref_50mhz;
    logic init_done;
  } rsc_gstat_t;

  localparam logic [3:0] ADDR_STRAP_DFLT = 4'h0;
  localparam rsc_strap_t STRAP_DFLT = '{
    neg_en: 1'b1, mode_hi: 1'b1, mode_lo: 1'b1,
    reduced: 1'b0, serial: 1'b0};
  localparam rsc_ctrl_t CTRL_RST = '{
    pd_state: 1'b0, mac_mode: MAC_MII,
    adv: ADV_10H | ADV_10F | ADV_100H | ADV_100F,
    duplex_full: 1'b1, speed_100: 1'b1, neg_en: 1'b1,
    irq_pin_en: 1'b0, station_addr: 5'h00};

endpackage

// ==== hdl/rsc_top.sv ====
// The address-and-strobe port and the address map are this design's own decisions.
module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned INIT_CYC = RESET_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [REG_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [REG_DW-1:0] reg_rdata_o,
  input wire logic [3:0] station_addr_strap_i,
  input wire logic [NUM_PORTS-1:0] negotiation_enable_strap_i,
  input wire logic [NUM_PORTS-1:0] link_mode_strap_high_i,
  input wire logic [NUM_PORTS-1:0] link_mode_strap_low_i,
  input wire logic [NUM_PORTS-1:0] mac_reduced_strap_i,
  input wire logic [NUM_PORTS-1:0] serial_if_strap_i,
  input wire logic sleep_or_irq_pin_first_i,
  output logic sleep_or_irq_pin_first_o,
  output logic sleep_or_irq_pin_first_oe_n_o,
  input wire logic sleep_or_irq_pin_second_i,
  output logic sleep_or_irq_pin_second_o,
  output logic sleep_or_irq_pin_second_oe_n_o,
  output logic [NUM_PORTS-1:0] power_down_o,
  output rsc_ctrl_t [NUM_PORTS-1:0] port_cfg_o,
  output logic init_done_o,
  output logic ref_50mhz_o,
  output logic rmii_mismatch_o,
  output logic irq_o
);

  localparam int CNT_W = $clog2(INIT_CYC + 1);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  rsc_state_t state_r;
  logic [CNT_W-1:0] init_cnt_r;
  logic init_done_r;
  logic capture;
  rsc_ctrl_t [NUM_PORTS-1:0] ctrl_r;
  rsc_strap_t [NUM_PORTS-1:0] strap_in;
  logic [NUM_PORTS-1:0] pin_in;
  logic [NUM_PORTS-1:0] pd_r;
  logic [NUM_PORTS-1:0] pd_nxt;
  logic [NUM_PORTS-1:0] oe_n_r;
  logic [NUM_PORTS-1:0] pin_o_r;
  logic [NUM_PORTS-1:0] ctrl_wr;
  logic [IRQ_W-1:0] ev_set;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] stat_nxt;
  logic [IRQ_W-1:0] stat_clr;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] pending;
  logic irq_r;
  logic ref_50mhz_r;
  logic mismatch_r;
  logic [REG_DW-1:0] rdata_r;
  rsc_gstat_t gstat;
  rsc_ctrl_t ctrl_wdata;

  assign pin_in = {sleep_or_irq_pin_second_i, sleep_or_irq_pin_first_i};
  // Write data seen through the control layout, so no field is hand-placed
  assign ctrl_wdata = reg_wdata_i;
  assign capture = clk_en_i && (state_r == ST_CAPTURE);

  // -------------------------------------------------------------------------
  // Reset sequencing
  // -------------------------------------------------------------------------
  // An async flop cannot load a pin, so the straps are taken on the first
  // enabled edge after release, while the pins still carry strap levels.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_CAPTURE; // [RULE_01] [RULE_02]
      init_cnt_r <= '0;
    end else if (clk_en_i) begin
      unique case (state_r)
        ST_CAPTURE: begin
          state_r <= ST_INIT;
          init_cnt_r <= '0;
        end
        ST_INIT: begin
          if (init_cnt_r == CNT_W'(INIT_CYC - 1)) begin
            state_r <= ST_RUN;
          end else begin
            init_cnt_r <= init_cnt_r + CNT_W'(1);
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN; // [RULE_17]
        end
      endcase
    end
  end

  // Internal settle time matches the least reset length
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_done_r <= 1'b0;
    end else if (clk_en_i) begin
      if (state_r == ST_INIT && init_cnt_r == CNT_W'(INIT_CYC - 1)) begin
        init_done_r <= 1'b1; // [RULE_01]
      end
    end
  end

  // -------------------------------------------------------------------------
  // Shared interface selection
  // -------------------------------------------------------------------------
  // Both ports share one reference; a split strapping is flagged, not fixed.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_50mhz_r <= STRAP_DFLT.reduced;
      mismatch_r <= 1'b0;
    end else if (capture) begin
      ref_50mhz_r <= &mac_reduced_strap_i; // [RULE_16]
      mismatch_r <= ^mac_reduced_strap_i; // [RULE_15]
    end
  end

  // -------------------------------------------------------------------------
  // Per-port logic
  // -------------------------------------------------------------------------
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port

    assign strap_in[g] = '{
      neg_en: negotiation_enable_strap_i[g],
      mode_hi: link_mode_strap_high_i[g],
      mode_lo: link_mode_strap_low_i[g],
      reduced: mac_reduced_strap_i[g],
      serial: serial_if_strap_i[g]};

    assign ctrl_wr[g] = reg_wr_i && (reg_addr_i == (g == 0 ?
                        ADDR_CTRL0 : ADDR_CTRL1));

    // Pin is power-down input unless software picked interrupt mode
    assign pd_nxt[g] = !ctrl_r[g].irq_pin_en && !pin_in[g]; // [RULE_03]

    assign ev_set[2*g+EV_PD_ENTER] = pd_nxt[g] && !pd_r[g];
    assign ev_set[2*g+EV_PD_EXIT] = !pd_nxt[g] && pd_r[g];

    // Port control register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ctrl_r[g] <= CTRL_RST; // [RULE_02] [RULE_09] [RULE_12]
      end else if (clk_en_i) begin
        if (state_r == ST_CAPTURE) begin // [RULE_06]
          ctrl_r[g].station_addr <= {station_addr_strap_i, 1'(g)}; // [RULE_07] [RULE_08]
          ctrl_r[g].neg_en <= strap_in[g].neg_en; // [RULE_10] [RULE_13]
          ctrl_r[g].speed_100 <= strap_in[g].mode_hi; // [RULE_11]
          ctrl_r[g].duplex_full <= strap_in[g].mode_lo; // [RULE_11]
          unique case ({strap_in[g].mode_hi, strap_in[g].mode_lo})
            2'b00: ctrl_r[g].adv <= ADV_10H | ADV_10F; // [RULE_12]
            2'b01: ctrl_r[g].adv <= ADV_100H | ADV_100F; // [RULE_12]
            2'b10: ctrl_r[g].adv <= ADV_10H | ADV_100H; // [RULE_12]
            2'b11: ctrl_r[g].adv <= ADV_10H | ADV_10F | ADV_100H
                                    | ADV_100F; // [RULE_12]
          endcase
          if (!strap_in[g].reduced) begin
            ctrl_r[g].mac_mode <= MAC_MII; // [RULE_14]
          end else if (!strap_in[g].serial) begin
            ctrl_r[g].mac_mode <= MAC_RMII; // [RULE_14]
          end else begin
            ctrl_r[g].mac_mode <= MAC_SNI;
          end
          ctrl_r[g].irq_pin_en <= CTRL_RST.irq_pin_en;
        end else if (ctrl_wr[g]) begin
          // Address and interface mode stay frozen from the strap sample
          ctrl_r[g].irq_pin_en <= ctrl_wdata.irq_pin_en; // [RULE_05]
          ctrl_r[g].neg_en <= ctrl_wdata.neg_en;
          ctrl_r[g].speed_100 <= ctrl_wdata.speed_100;
          ctrl_r[g].duplex_full <= ctrl_wdata.duplex_full;
          ctrl_r[g].adv <= ctrl_wdata.adv;
        end
        ctrl_r[g].pd_state <= pd_nxt[g];
      end
    end

    // Power-down state and open-drain drive
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pd_r[g] <= 1'b0;
        oe_n_r[g] <= 1'b1;
        pin_o_r[g] <= 1'b0;
      end else if (clk_en_i) begin
        pd_r[g] <= pd_nxt[g]; // [RULE_03]
        // Only ever drives low; release lets the pull-up win
        oe_n_r[g] <= !(ctrl_r[g].irq_pin_en
                       && |pending[2*g +: 2]); // [RULE_04]
        pin_o_r[g] <= 1'b0; // [RULE_04]
      end
    end

  end

  // -------------------------------------------------------------------------
  // Interrupt status and mask
  // -------------------------------------------------------------------------
  assign stat_clr = (reg_wr_i && reg_addr_i == ADDR_IRQ_STAT) ?
                    reg_wdata_i[IRQ_W-1:0] : '0;
  // A new event beats a clear landing in the same cycle
  assign stat_nxt = (stat_r & ~stat_clr) | ev_set;
  assign pending = stat_r & mask_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_r <= '0;
    end else if (clk_en_i) begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_r <= '0;
    end else if (clk_en_i) begin
      if (reg_wr_i && reg_addr_i == ADDR_IRQ_MASK) begin
        mask_r <= reg_wdata_i[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 1'b0;
    end else if (clk_en_i) begin
      irq_r <= |pending;
    end
  end

  // -------------------------------------------------------------------------
  // Register read
  // -------------------------------------------------------------------------
  assign gstat = '{
    zero: '0,
    rmii_mismatch: mismatch_r,
    ref_50mhz: ref_50mhz_r,
    init_done: init_done_r};

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= '0;
    end else if (clk_en_i) begin
      rdata_r <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          ADDR_CTRL0: rdata_r <= ctrl_r[0];
          ADDR_CTRL1: rdata_r <= ctrl_r[1];
          ADDR_IRQ_STAT: rdata_r <= REG_DW'(stat_r);
          ADDR_IRQ_MASK: rdata_r <= REG_DW'(mask_r);
          ADDR_GSTAT: rdata_r <= gstat;
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign reg_rdata_o = rdata_r;
  assign power_down_o = pd_r;
  assign port_cfg_o = ctrl_r;
  assign init_done_o = init_done_r;
  assign ref_50mhz_o = ref_50mhz_r;
  assign rmii_mismatch_o = mismatch_r;
  assign irq_o = irq_r;
  assign sleep_or_irq_pin_first_o = pin_o_r[0];
  assign sleep_or_irq_pin_first_oe_n_o = oe_n_r[0];
  assign sleep_or_irq_pin_second_o = pin_o_r[1];
  assign sleep_or_irq_pin_second_oe_n_o = oe_n_r[1];

endmodule

// ==== tb/rsc_board_model.sv ====
module rsc_board_model
  import rsc_pkg::*;
(
  input wire logic [3:0] addr_fit_i,
  input wire logic [3:0] addr_val_i,
  input wire logic [NUM_PORTS-1:0] sleep_req_i,
  input wire logic [NUM_PORTS-1:0] pin_drv_i,
  input wire logic [NUM_PORTS-1:0] pin_oe_n_i,
  output logic [3:0] station_addr_strap_o,
  output logic [NUM_PORTS-1:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unfitted straps fall to the weak pull-down
  assign station_addr_strap_o = addr_fit_i & addr_val_i;
  // Pull-up unless the switch or the device pulls low
  assign pin_lvl_o = ~(sleep_req_i | (~pin_oe_n_i & ~pin_drv_i));
endmodule

// ==== tb/rsc_checker.sv ====
module rsc_checker
  import rsc_pkg::*;
#(
  parameter int unsigned INIT_CYC = RESET_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic [3:0] station_addr_strap_i,
  input wire logic [NUM_PORTS-1:0] negotiation_enable_strap_i,
  input wire logic [NUM_PORTS-1:0] link_mode_strap_high_i,
  input wire logic [NUM_PORTS-1:0] mac_reduced_strap_i,
  input wire logic sleep_or_irq_pin_first_i,
  input wire logic sleep_or_irq_pin_first_o,
  input wire logic sleep_or_irq_pin_first_oe_n_o,
  input wire logic [NUM_PORTS-1:0] power_down_o,
  input wire rsc_ctrl_t [NUM_PORTS-1:0] port_cfg_o,
  input wire logic init_done_o,
  input wire logic ref_50mhz_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic cap_done_r;
  logic [7:0] en_cnt_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_done_r <= 1'b0;
      en_cnt_r <= 8'h00;
    end else if (clk_en_i) begin
      cap_done_r <= 1'b1;
      en_cnt_r <= en_cnt_r + {7'h00, en_cnt_r != 8'hff};
    end
  end
  property p_pd_follow;
    clk_en_i && !port_cfg_o[0].irq_pin_en
    |=> power_down_o[0] == !$past(sleep_or_irq_pin_first_i);
  endproperty
  a_pd_follow: assert property (p_pd_follow)
    else $error("power-down does not follow pin");
  property p_pd_refused;
    clk_en_i && port_cfg_o[0].irq_pin_en |=> !power_down_o[0];
  endproperty
  a_pd_refused: assert property (p_pd_refused)
    else $error("power-down while pin is interrupt");
  property p_irq_drive;
    !sleep_or_irq_pin_first_oe_n_o
    |-> !sleep_or_irq_pin_first_o && $past(port_cfg_o[0].irq_pin_en);
  endproperty
  a_irq_drive: assert property (p_irq_drive)
    else $error("pin driven outside interrupt mode");
  property p_addr_cap;
    clk_en_i && !cap_done_r
    |=> port_cfg_o[0].station_addr == {$past(station_addr_strap_i), 1'b0}
      && port_cfg_o[1].station_addr == {$past(station_addr_strap_i), 1'b1};
  endproperty
  a_addr_cap: assert property (p_addr_cap)
    else $error("station address capture wrong");
  property p_frozen;
    cap_done_r |=> $stable(port_cfg_o[0].station_addr);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("station address changed after capture");
  property p_mode_cap;
    clk_en_i && !cap_done_r
    |=> port_cfg_o[0].neg_en == $past(negotiation_enable_strap_i[0])
      && port_cfg_o[0].speed_100 == $past(link_mode_strap_high_i[0]);
  endproperty
  a_mode_cap: assert property (p_mode_cap)
    else $error("mode strap capture wrong");
  property p_mii;
    clk_en_i && !cap_done_r && !mac_reduced_strap_i[1]
    |=> port_cfg_o[1].mac_mode == MAC_MII;
  endproperty
  a_mii: assert property (p_mii)
    else $error("interface mode not standard");
  property p_ref50;
    $past(cap_done_r, 2) |-> ref_50mhz_o == (port_cfg_o[0].mac_mode
      != MAC_MII && port_cfg_o[1].mac_mode != MAC_MII);
  endproperty
  a_ref50: assert property (p_ref50)
    else $error("reference rate flag wrong");
  property p_init;
    $rose(init_done_o) |-> en_cnt_r == INIT_CYC + 1;
  endproperty
  a_init: assert property (p_init)
    else $error("init done at wrong count");
endmodule

bind rsc_top rsc_checker #(.INIT_CYC(INIT_CYC)) i_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
  .station_addr_strap_i(station_addr_strap_i),
  .negotiation_enable_strap_i(negotiation_enable_strap_i),
  .link_mode_strap_high_i(link_mode_strap_high_i),
  .mac_reduced_strap_i(mac_reduced_strap_i),
  .sleep_or_irq_pin_first_i(sleep_or_irq_pin_first_i),
  .sleep_or_irq_pin_first_o(sleep_or_irq_pin_first_o),
  .sleep_or_irq_pin_first_oe_n_o(sleep_or_irq_pin_first_oe_n_o),
  .power_down_o(power_down_o), .port_cfg_o(port_cfg_o),
  .init_done_o(init_done_o), .ref_50mhz_o(ref_50mhz_o));

// ==== tb/tb_top.sv ====
module tb_top;
  import rsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, en = 1;
  logic [3:0] addr = 0, fit = 0, aval = 0, sa;
  logic [15:0] wdata = 0, rdata;
  logic [1:0] neg = 3, hi = 3, lo = 3, red = 0, ser = 0, sleep = 0;
  logic [1:0] pdrv, poe_n, pdn, lvl;
  rsc_ctrl_t [1:0] cfg;
  logic done, r50, mis, irq;
  int mismatches = 0, total_checks = 0, cyc = 0, seed = 33128;
  initial forever #20 clk = ~clk;
  rsc_board_model i_board (.addr_fit_i(fit), .addr_val_i(aval),
    .sleep_req_i(sleep), .pin_drv_i(pdrv), .pin_oe_n_i(poe_n),
    .station_addr_strap_o(sa), .pin_lvl_o(lvl));
  rsc_top #(.INIT_CYC(2)) i_dut (.ref_clk_i(clk), .arst_n_i(rst_n),
    .clk_en_i(en), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .station_addr_strap_i(sa), .negotiation_enable_strap_i(neg),
    .link_mode_strap_high_i(hi), .link_mode_strap_low_i(lo),
    .mac_reduced_strap_i(red), .serial_if_strap_i(ser),
    .sleep_or_irq_pin_first_i(lvl[0]), .sleep_or_irq_pin_first_o(pdrv[0]),
    .sleep_or_irq_pin_first_oe_n_o(poe_n[0]),
    .sleep_or_irq_pin_second_i(lvl[1]),
    .sleep_or_irq_pin_second_o(pdrv[1]),
    .sleep_or_irq_pin_second_oe_n_o(poe_n[1]), .power_down_o(pdn),
    .port_cfg_o(cfg), .init_done_o(done), .ref_50mhz_o(r50),
    .rmii_mismatch_o(mis), .irq_o(irq));
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic rsc_ctrl_t exp_cfg(input int p);
    rsc_ctrl_t e;
    e = '0;
    e.station_addr = {fit & aval, p[0]};
    e.neg_en = neg[p];
    e.speed_100 = hi[p];
    e.duplex_full = lo[p];
    case ({hi[p], lo[p]})
      2'b00: e.adv = ADV_10H | ADV_10F;
      2'b01: e.adv = ADV_100H | ADV_100F;
      2'b10: e.adv = ADV_10H | ADV_100H;
      default: e.adv = ADV_10H | ADV_10F | ADV_100H | ADV_100F;
    endcase
    e.mac_mode = !red[p] ? MAC_MII : (ser[p] ? MAC_SNI : MAC_RMII);
    return e;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Negative k keeps every strap at its default
  task automatic do_reset(input int k);
    rsc_ctrl_t e0, e1;
    logic [15:0] g;
    @(posedge clk);
    rst_n <= 1'b0;
    fit <= k < 0 ? 4'h0 : 4'($random(seed));
    aval <= 4'($random(seed));
    neg <= k < 0 ? 2'h3 : {1'($random(seed)), k[2]};
    hi <= k < 0 ? 2'h3 : {1'($random(seed)), k[1]};
    lo <= k < 0 ? 2'h3 : {1'($random(seed)), k[0]};
    red <= k < 0 ? 2'h0 : {2{k[1]}};
    ser <= k < 0 ? 2'h0 : {2{k[2]}};
    repeat (25) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 e0 = exp_cfg(0);
    e1 = exp_cfg(1);
    if (k < 0) chk(e0, CTRL_RST);
    chk(cfg[0], e0);
    chk(cfg[1], e1);
    chk({r50, mis}, {&red, 1'b0});
    @(posedge clk);
    aval <= ~aval;
    fit <= 4'hf;
    neg <= ~neg;
    lo <= ~lo;
    repeat (4) @(posedge clk);
    #1 chk(cfg[0], e0);
    rd_reg(ADDR_CTRL1, g);
    chk(g, e1);
    rd_reg(ADDR_IRQ_STAT, g);
    chk(g, 16'h0000);
    chk(done, 1'b1);
  endtask
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    logic [15:0] g;
    do_reset(-1);
    for (int k = 0; k < 8; k++) do_reset(k);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) sleep[p] <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(pdn[p], 1'b1);
      @(posedge clk) sleep[p] <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(pdn[p], 1'b0);
    end
    // Clock enable low must freeze the power-down state
    @(posedge clk) begin
      en <= 1'b0;
      sleep[1] <= 1'b1;
    end
    repeat (3) @(posedge clk);
    #1 chk({pdn[1], irq}, 2'b00);
    @(posedge clk) begin
      sleep[1] <= 1'b0;
      en <= 1'b1;
    end
    rd_reg(ADDR_IRQ_STAT, g);
    chk(g, 16'h000f);
    wr_reg(ADDR_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk({irq, poe_n[0]}, 2'b11);
    rd_reg(ADDR_CTRL0, g);
    wr_reg(ADDR_CTRL0, g | 16'h0020);
    @(posedge clk) sleep[0] <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({poe_n[0], lvl[0], pdn[0]}, 3'b000);
    @(posedge clk) sleep[0] <= 1'b0;
    wr_reg(ADDR_IRQ_STAT, 16'h0001);
    repeat (3) @(posedge clk);
    #1 chk({irq, poe_n[0], lvl[0]}, 3'b011);
    rd_reg(4'hf, g);
    chk(g, 16'h0000);
    do_reset(-1);
    rd_reg(ADDR_CTRL0, g);
    chk(g, CTRL_RST);
    close_out();
  end
endmodule
